/* rtl/pfr_pkg.sv */
package pfr_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_CORE_FLAGS = 8'h03;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h04;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h05;
  localparam logic [7:0] IDX_PC_VIEW = 8'h06;
  // core flag register layout
  localparam int PAGE_LSB = 5;
  localparam int TIMEOUT_BIT = 4;
  localparam int POWERDOWN_BIT = 3;
  localparam logic [7:0] FLAGS_POR = 8'h18;
  localparam logic [7:0] FLAGS_WR_MASK = 8'he7;
  // interrupt event bits
  localparam int EV_RESET_DONE = 0;
  localparam int EV_STACK_LOST = 1;
  localparam int EV_PAGE_ROLL = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] EV_RESET_VAL = 3'h0;
  // program counter and phase defaults
  localparam int PC_W_DEF = 11;
  localparam int WORD_W = 12;
  localparam logic [3:0] PHASE_FIRST = 4'h1;
  localparam logic [3:0] PHASE_IDLE = 4'h0;
  // reset release timer
  localparam int DRT_MS = 18;
  localparam int CLK_MHZ = 200;
  localparam int DRT_CYCLES = DRT_MS * CLK_MHZ * 1000;
endpackage

/* rtl/pfr_core.sv */
// Chosen here: register access over APB.
`timescale 1ns/1ps
module pfr_core #(
  parameter int PC_W = pfr_pkg::PC_W_DEF,
  parameter int DRT_CYC = pfr_pkg::DRT_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_clear_pin,
  input wire logic wdt_timeout,
  input wire logic sleep_mode,
  output logic [PC_W-1:0] pmem_addr,
  input wire logic [pfr_pkg::WORD_W-1:0] pmem_data,
  output logic [pfr_pkg::WORD_W-1:0] instr_reg,
  output logic exec_valid,
  input wire logic xfer_jump,
  input wire logic xfer_call,
  input wire logic xfer_ret,
  input wire logic xfer_pcl,
  input wire logic [8:0] xfer_low9,
  input wire logic [7:0] ret_literal,
  output logic w_load,
  output logic [7:0] w_literal,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic first_phase,
  output logic second_phase,
  output logic third_phase,
  output logic fourth_phase,
  output logic [7:0] core_flags,
  output logic int_reset,
  output logic irq
);
  localparam int PG_W = PC_W - 9;
  localparam logic [PC_W-1:0] RESET_VEC = {PC_W{1'b1}};
  localparam logic [31:0] DRT_LAST = 32'(DRT_CYC - 1);

  logic [2:0] mc_sync_r;
  logic master_clear_pin_lvl_r;
  logic int_rst_r;
  logic [31:0] drt_cnt_r;
  logic [3:0] ph_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] fetch_addr_r;
  logic [pfr_pkg::WORD_W-1:0] fetch_ir_r;
  logic fetch_valid_r;
  logic [pfr_pkg::WORD_W-1:0] exec_ir_r;
  logic exec_valid_r;
  logic [PC_W-1:0] stack1_r;
  logic [PC_W-1:0] stack2_r;
  logic [1:0] depth_r;
  logic w_load_r;
  logic [7:0] w_literal_r;
  logic dmem_rd_r;
  logic dmem_wr_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [pfr_pkg::EV_W-1:0] ev_stat_r;
  logic [pfr_pkg::EV_W-1:0] ev_mask_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // master clear pin: a change counts once the last two stages agree
  wire mc_stable = mc_sync_r[1] == mc_sync_r[2];
  wire master_clear_pin_fall = mc_stable && !mc_sync_r[2] && master_clear_pin_lvl_r;
  wire master_clear_pin_low = !master_clear_pin_lvl_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mc_sync_r <= 3'h0;
      master_clear_pin_lvl_r <= 1'b0;
    end else begin
      mc_sync_r <= {mc_sync_r[1:0], master_clear_pin};
      if (mc_stable) begin
        master_clear_pin_lvl_r <= mc_sync_r[2];
      end
    end
  end

  // reset latch and release timer; the async reset is the rising-supply
  // detector, a falling supply has no path into it
  wire rst_cause = master_clear_pin_low || wdt_timeout;
  wire drt_done = int_rst_r && !rst_cause && (drt_cnt_r == DRT_LAST);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      int_rst_r <= 1'b1;
      drt_cnt_r <= 32'h0;
    end else begin
      if (rst_cause) begin
        int_rst_r <= 1'b1;
        drt_cnt_r <= 32'h0;
      end else if (drt_done) begin
        int_rst_r <= 1'b0;
      end else if (int_rst_r) begin
        drt_cnt_r <= drt_cnt_r + 32'h1;
      end
    end
  end

  // phase generator: idle during reset, restarts at the first phase
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= pfr_pkg::PHASE_IDLE;
    end else if (int_rst_r) begin
      ph_r <= drt_done ? pfr_pkg::PHASE_FIRST : pfr_pkg::PHASE_IDLE;
    end else begin
      ph_r <= {ph_r[2:0], ph_r[3]};
    end
  end

  // control transfer decode, acted on at the fourth phase of execute
  wire at_q4 = ph_r[3] && !int_rst_r;
  wire do_call = at_q4 && exec_valid_r && xfer_call;
  wire do_ret = at_q4 && exec_valid_r && xfer_ret && !xfer_call;
  wire do_page = at_q4 && exec_valid_r && (xfer_jump || xfer_pcl) && !xfer_call && !xfer_ret;
  wire do_xfer = do_call || do_ret || do_page;
  wire [PG_W-1:0] page_sel = flags_r[pfr_pkg::PAGE_LSB +: PG_W];
  wire [PC_W-1:0] page_target = {page_sel, xfer_low9};
  wire pc_step = ph_r[0] && !int_rst_r;
  wire page_roll = pc_step && (pc_r[8:0] == 9'h1ff);

  // program counter and fetch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_r <= RESET_VEC;
      fetch_addr_r <= RESET_VEC;
      fetch_ir_r <= '0;
      fetch_valid_r <= 1'b0;
    end else if (int_rst_r) begin
      pc_r <= RESET_VEC;
      fetch_addr_r <= RESET_VEC;
      fetch_valid_r <= 1'b0;
    end else begin
      if (pc_step) begin
        fetch_addr_r <= pc_r;
        pc_r <= pc_r + PC_W'(1);
      end else if (do_ret) begin
        pc_r <= stack1_r;
      end else if (do_xfer) begin
        pc_r <= page_target;
      end
      if (ph_r[3]) begin
        fetch_ir_r <= pmem_data;
        fetch_valid_r <= !do_xfer;
      end
    end
  end

  // execute stage takes the fetched word while the next fetch begins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      exec_ir_r <= '0;
      exec_valid_r <= 1'b0;
    end else if (int_rst_r) begin
      exec_valid_r <= 1'b0;
    end else if (ph_r[0]) begin
      exec_ir_r <= fetch_ir_r;
      exec_valid_r <= fetch_valid_r;
    end
  end

  // data memory strobes follow the executing word
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dmem_rd_r <= 1'b0;
      dmem_wr_r <= 1'b0;
    end else begin
      dmem_rd_r <= ph_r[1] && exec_valid_r && !int_rst_r;
      dmem_wr_r <= ph_r[3] && exec_valid_r && !int_rst_r;
    end
  end

  // return stack entries are left alone by resets other than power-on; depth_r clears in reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stack1_r <= '0;
      stack2_r <= '0;
      depth_r <= 2'h0;
      w_load_r <= 1'b0;
      w_literal_r <= 8'h0;
    end else begin
      w_load_r <= do_ret;
      if (do_call) begin
        stack2_r <= stack1_r;
        stack1_r <= fetch_addr_r;
        depth_r <= (depth_r == 2'h2) ? 2'h2 : depth_r + 2'h1;
      end else if (do_ret) begin
        stack1_r <= stack2_r;
        w_literal_r <= ret_literal;
        depth_r <= (depth_r == 2'h0) ? 2'h0 : depth_r - 2'h1;
      end else if (int_rst_r) begin
        depth_r <= 2'h0;
      end
    end
  end

  // register bus decode
  wire setup = psel && !penable;
  wire acc_done = psel && penable && pready_r;
  wire [5:0] idx = paddr[7:2];
  wire sel_flags = idx == pfr_pkg::IDX_CORE_FLAGS[5:0];
  wire sel_stat = idx == pfr_pkg::IDX_IRQ_STATUS[5:0];
  wire sel_mask = idx == pfr_pkg::IDX_IRQ_MASK[5:0];
  wire sel_pc = idx == pfr_pkg::IDX_PC_VIEW[5:0];
  wire addr_ok = (paddr[1:0] == 2'h0) && (sel_flags || sel_stat || sel_mask || sel_pc);
  wire wr_flags = acc_done && pwrite && sel_flags && addr_ok;
  wire wr_stat = acc_done && pwrite && sel_stat && addr_ok;
  wire wr_mask = acc_done && pwrite && sel_mask && addr_ok;
  wire [31:0] rd_mux = !addr_ok ? 32'h0 :
                       sel_flags ? {24'h0, flags_r} :
                       sel_stat ? {29'h0, ev_stat_r} :
                       sel_mask ? {29'h0, ev_mask_r} :
                       32'(pc_r);

  // flag update per reset cause; master clear wins over a same-cycle watchdog
  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = (flags_r & ~pfr_pkg::FLAGS_WR_MASK) | (pwdata[7:0] & pfr_pkg::FLAGS_WR_MASK);
    end
    if (master_clear_pin_fall) begin
      if (sleep_mode) begin
        flags_nxt[pfr_pkg::TIMEOUT_BIT] = 1'b1;
        flags_nxt[pfr_pkg::POWERDOWN_BIT] = 1'b0;
      end
    end else if (wdt_timeout) begin
      flags_nxt[pfr_pkg::TIMEOUT_BIT] = 1'b0;
      flags_nxt[pfr_pkg::POWERDOWN_BIT] = !sleep_mode;
    end
    if (int_rst_r || rst_cause) begin
      flags_nxt[7:pfr_pkg::PAGE_LSB] = 3'h0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= pfr_pkg::FLAGS_POR;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // sticky events: a set in the same cycle as a clearing write wins
  wire [pfr_pkg::EV_W-1:0] ev_set = {page_roll, do_call && (depth_r == 2'h2), drt_done};
  wire [pfr_pkg::EV_W-1:0] ev_clr = wr_stat ? pwdata[pfr_pkg::EV_W-1:0] : '0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ev_stat_r <= pfr_pkg::EV_RESET_VAL;
      ev_mask_r <= pfr_pkg::EV_RESET_VAL;
      irq_r <= 1'b0;
    end else begin
      ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
      if (wr_mask) begin
        ev_mask_r <= pwdata[pfr_pkg::EV_W-1:0];
      end
      irq_r <= |(((ev_stat_r & ~ev_clr) | ev_set) & (wr_mask ? pwdata[2:0] : ev_mask_r));
    end
  end

  // answer is prepared in the setup cycle, so the access phase ends at once
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0 : rd_mux;
      pready_r <= 1'b1;
      pslverr_r <= !addr_ok;
    end else if (acc_done) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pmem_addr = fetch_addr_r;
  assign instr_reg = exec_ir_r;
  assign exec_valid = exec_valid_r;
  assign w_load = w_load_r;
  assign w_literal = w_literal_r;
  assign dmem_rd = dmem_rd_r;
  assign dmem_wr = dmem_wr_r;
  assign first_phase = ph_r[0];
  assign second_phase = ph_r[1];
  assign third_phase = ph_r[2];
  assign fourth_phase = ph_r[3];
  assign core_flags = flags_r;
  assign int_reset = int_rst_r;
  assign irq = irq_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_push;
    stack2_r == $past(stack1_r) && stack1_r == $past(fetch_addr_r);
  endsequence
  sequence s_flush;
    !fetch_valid_r ##1 !exec_valid_r;
  endsequence

  AST_PHASE_ONEHOT: assert property ($onehot0(ph_r) && (int_rst_r || ph_r != 4'h0))
    else $error("phase set not one-hot while running");
  AST_PHASE_SEQ: assert property (ph_r[0] && !int_rst_r && !rst_cause |=> ph_r[1] && !ph_r[0])
    else $error("second phase did not follow first");
  AST_PC_INC: assert property (pc_step |=> pc_r == PC_W'($past(pc_r) + 1'b1))
    else $error("pc did not increment in first phase");
  AST_IR_CAPTURE: assert property (at_q4 |=> fetch_ir_r == $past(pmem_data))
    else $error("fetched word not captured in fourth phase");
  AST_FLUSH: assert property (do_xfer && !rst_cause |=> s_flush)
    else $error("prefetched word not discarded");
  AST_DMEM: assert property (dmem_rd_r |-> ph_r[2] ##2 (dmem_wr_r || int_rst_r))
    else $error("data strobes out of phase");
  AST_WDT_FLAGS: assert property (wdt_timeout && !master_clear_pin_fall && !wr_flags |=>
      flags_r[4:3] == {1'b0, !$past(sleep_mode)})
    else $error("watchdog flags wrong");
  AST_TIMER_HOLD: assert property (master_clear_pin_low |=> drt_cnt_r == 32'h0 && int_rst_r)
    else $error("release timer ran while master clear low");
  AST_RESET_STATE: assert property (int_rst_r |=> pc_r == RESET_VEC
      && flags_r[7:5] == 3'h0)
    else $error("reset vector or page select not set");
  AST_CALL_PUSH: assert property (do_call |=> s_push)
    else $error("call push wrong");
  AST_RET_POP: assert property (do_ret |=> pc_r == $past(stack1_r)
      && stack1_r == $past(stack2_r) && stack2_r == $past(stack2_r) && w_load_r)
    else $error("return pop wrong");
  AST_RELEASE: assert property ($fell(int_rst_r) |-> ph_r[0] && !exec_valid_r
      && !fetch_valid_r && fetch_addr_r == RESET_VEC)
    else $error("restart after reset not clean");
endmodule

/* bench/pfr_pmem_model.sv */
`timescale 1ns/1ps
module pfr_pmem_model #(
  parameter int AW = 11
) (
  input wire logic mclk,
  input wire logic [AW-1:0] addr,
  output logic [11:0] data,
  input wire logic cond_ok,
  output logic master_clear_pin
);
  // word derived from its address so a fetch from the wrong place shows up
  always_ff @(posedge mclk) data <= 12'(addr) ^ 12'ha5a;
  // pin held low until the bench reports valid operating conditions
  assign master_clear_pin = cond_ok;
endmodule

/* bench/tb_program_flow_and_reset.sv */
`timescale 1ns/1ps
module tb_program_flow_and_reset;
  localparam int RESET_RELEASE_TIMER = 20;
  localparam logic [7:0] A_FL = pfr_pkg::IDX_CORE_FLAGS << 2;
  localparam logic [7:0] A_ST = pfr_pkg::IDX_IRQ_STATUS << 2;
  localparam logic [7:0] A_MK = pfr_pkg::IDX_IRQ_MASK << 2;
  localparam logic [7:0] A_PC = pfr_pkg::IDX_PC_VIEW << 2;
  logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0, ret_literal = 8'h0, w_literal, core_flags;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic pready, pslverr, re, master_clear_pin, cond_ok = 1'b0;
  logic wdt_timeout = 1'b0, sleep_mode = 1'b0, exec_valid, w_load, dmem_rd, dmem_wr;
  logic xfer_jump = 1'b0, xfer_call = 1'b0, xfer_ret = 1'b0, xfer_pcl = 1'b0;
  logic [8:0] xfer_low9 = 9'h0;
  logic [10:0] pmem_addr, last_fetch, r1, r2;
  logic [11:0] pmem_data, instr_reg;
  logic first_phase, second_phase, third_phase, fourth_phase, int_reset, irq;
  logic [3:0] ph_q = 4'h0;
  int mismatches = 0, cmp_count = 0, n;
  always #2.5 mclk = ~mclk;
  pfr_core #(.PC_W(11), .DRT_CYC(RESET_RELEASE_TIMER)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_pin(master_clear_pin), .wdt_timeout(wdt_timeout),
    .sleep_mode(sleep_mode), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .instr_reg(instr_reg), .exec_valid(exec_valid), .xfer_jump(xfer_jump),
    .xfer_call(xfer_call), .xfer_ret(xfer_ret), .xfer_pcl(xfer_pcl),
    .xfer_low9(xfer_low9), .ret_literal(ret_literal), .w_load(w_load),
    .w_literal(w_literal), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .first_phase(first_phase), .second_phase(second_phase), .third_phase(third_phase),
    .fourth_phase(fourth_phase), .core_flags(core_flags), .int_reset(int_reset), .irq(irq)
  );
  pfr_pmem_model #(.AW(11)) i_mem (
    .mclk(mclk), .addr(pmem_addr), .data(pmem_data), .cond_ok(cond_ok),
    .master_clear_pin(master_clear_pin)
  );
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    chk(1'b0, "timeout");
    results();
  endtask
  function automatic logic [11:0] wexp(input logic [10:0] a);
    return {1'b0, a} ^ 12'ha5a;
  endfunction
  // outputs are read at the edge itself, so they still show the cycle just ended
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_rel(output int c);
    c = 0;
    while (int_reset !== 1'b0) begin
      @(posedge mclk);
      c++;
      if (c > 60) hang();
    end
    chk(first_phase === 1'b1 && exec_valid === 1'b0, "restart");
    chk(pmem_addr === 11'h7ff, "vector");
  endtask
  task automatic wait_exec(input logic [10:0] a, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
      if (c > 24) hang();
    end while (!(exec_valid === 1'b1 && instr_reg === wexp(a)));
  endtask
  task automatic xfer(input int k, input logic [8:0] lo, input logic [7:0] lit);
    int i = 0;
    do begin
      @(posedge mclk);
      i++;
      if (i > 12) hang();
    end while (!(third_phase === 1'b1 && exec_valid === 1'b1));
    xfer_jump <= (k == 0);
    xfer_call <= (k == 1);
    xfer_ret <= (k == 2);
    xfer_pcl <= (k == 3);
    xfer_low9 <= lo;
    ret_literal <= lit;
    @(posedge mclk);
    last_fetch = pmem_addr;
    xfer_jump <= 1'b0;
    xfer_call <= 1'b0;
    xfer_ret <= 1'b0;
    xfer_pcl <= 1'b0;
    @(posedge mclk);
    // w_load stands one cycle; exec_valid drops only at the end of the first phase
    chk(w_load === (k == 2) && (k != 2 || w_literal === lit), "literal");
    @(posedge mclk);
    chk(exec_valid === 1'b0, "prefetch kept");
  endtask
  always @(posedge mclk) begin
    if (int_reset === 1'b0 && ph_q !== 4'h0) begin
      chk({fourth_phase, third_phase, second_phase, first_phase} === {ph_q[2:0], ph_q[3]},
          "phase");
    end
    if (dmem_rd === 1'b1) chk(third_phase === 1'b1, "read phase");
    if (dmem_wr === 1'b1) chk(first_phase === 1'b1, "write phase");
    ph_q <= {fourth_phase, third_phase, second_phase, first_phase};
  end
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    rd(A_PC);
    chk(rq === 32'h7ff, "pc");
    rd(A_FL);
    chk(rq === 32'h18, "por flags");
    repeat (40) @(posedge mclk);
    chk(int_reset === 1'b1, "held");
    cond_ok <= 1'b1;
    @(posedge mclk);
    wait_rel(n);
    chk(n >= RESET_RELEASE_TIMER && n <= RESET_RELEASE_TIMER + 8, "release time");
    wait_exec(11'h7ff, n);
    rd(A_ST);
    chk(rq[pfr_pkg::EV_RESET_DONE] === 1'b1 && irq === 1'b0, "masked event");
    wr(A_MK, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq === 1'b1, "irq on");
    // also clears the page event left by the wrap from the reset vector
    wr(A_ST, 32'h5);
    repeat (2) @(posedge mclk);
    chk(irq === 1'b0, "irq clear");
    rd(8'h40);
    chk(re === 1'b1 && rq === 32'h0, "unmapped");
    // read-only flag bits written as zero must survive
    wr(A_FL, 32'h25);
    rd(A_FL);
    chk(rq === 32'h3d, "flag write");
    xfer(0, 9'h1ff, 8'h0);
    wait_exec(11'h3ff, n);
    wait_exec(11'h400, n);
    chk(n == 4, "rollover");
    rd(A_FL);
    chk(rq[7:5] === 3'h1, "page kept");
    xfer(3, 9'h0c0, 8'h0);
    wait_exec(11'h2c0, n);
    xfer(1, 9'h040, 8'h0);
    r1 = last_fetch;
    wait_exec(11'h240, n);
    xfer(1, 9'h080, 8'h0);
    r2 = last_fetch;
    wait_exec(11'h280, n);
    xfer(2, 9'h0, 8'h3c);
    wait_exec(r2, n);
    xfer(2, 9'h0, 8'hc3);
    wait_exec(r1, n);
    xfer(2, 9'h0, 8'h5a);
    wait_exec(r1, n);
    repeat (3) xfer(1, 9'h100, 8'h0);
    rd(A_ST);
    chk(rq[pfr_pkg::EV_STACK_LOST] === 1'b1 && rq[pfr_pkg::EV_PAGE_ROLL] === 1'b1,
        "stack and page events");
    for (int c = 0; c < 4; c++) begin
      wr(A_FL, 32'h25);
      sleep_mode <= c[0];
      @(posedge mclk);
      if (c == 0 || c == 3) begin
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
      end else begin
        // low long enough to pass the pin synchroniser
        cond_ok <= 1'b0;
        repeat (8) @(posedge mclk);
        cond_ok <= 1'b1;
      end
      @(posedge mclk);
      sleep_mode <= 1'b0;
      wait_rel(n);
      rd(A_FL);
      chk(rq === {27'h0, (c == 1 || c == 2), (c == 0), 3'h5}, "cause flags");
      chk(core_flags === rq[7:0], "flag port");
    end
    results();
  end
endmodule
